// ===== verilog/rca_defs.svh
// Offsets, field positions and reset values of the clock configuration block
`ifndef RCA_DEFS_SVH
`define RCA_DEFS_SVH

// ==========================================================
// Register byte offsets
`define RCA_OFS_CFG 8'h00
`define RCA_OFS_VAL_HIGH 8'h04
`define RCA_OFS_VAL_LOW 8'h08

// ==========================================================
// Configuration word fields
`define RCA_CFG_RESET 16'h0000
`define RCA_BIT_RUN 15
`define RCA_BIT_UNLOCK 13
`define RCA_BIT_SYNC 12
`define RCA_BIT_HALF 11
`define RCA_BIT_OUTEN 10
`define RCA_PTR_MSB 9
`define RCA_PTR_LSB 8
`define RCA_CAL_MSB 7
`define RCA_CAL_LSB 0

// ==========================================================
// Bus answers
`define RCA_RESP_OKAY 2'h0
`define RCA_RESP_SLVERR 2'h2

`endif

// ===== verilog/rca_pkg.sv
// Types shared by the clock configuration block
package rca_pkg;

  // ==========================================================
  // Value window pointer codes
  typedef enum logic [1:0] {
    RCA_PTR_MINUTES = 2'h0,
    RCA_PTR_WEEKDAY = 2'h1,
    RCA_PTR_MONTH = 2'h2,
    RCA_PTR_RSVD = 2'h3
  } rca_ptr_t;

  // Register select, one-hot
  typedef enum logic [3:0] {
    RCA_SEL_NONE = 4'h1,
    RCA_SEL_CFG = 4'h2,
    RCA_SEL_HIGH = 4'h4,
    RCA_SEL_LOW = 4'h8
  } rca_sel_t;

  // ==========================================================
  // Time fields from the counters
  typedef struct packed {
    logic [7:0] minutes;
    logic [7:0] weekday;
    logic [7:0] month;
    logic [7:0] seconds;
  } rca_fields_t;

  // Write request from the bus front end
  typedef struct packed {
    logic req;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } rca_wr_t;

  // Bus front end state
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rca_axil_state_t;

  // Software-held configuration
  typedef struct packed {
    logic run;
    logic unlock;
    logic out_en;
    rca_ptr_t ptr;
    logic [7:0] cal;
  } rca_cfg_t;

  // Core state
  typedef struct packed {
    rca_cfg_t cfg;
    logic sync;
    logic half;
    logic fwr;
    logic fwr_seconds;
    rca_ptr_t fwr_ptr;
    logic [7:0] fwr_data;
  } rca_core_t;

endpackage

// ===== verilog/rca_axil_slave.sv
// AXI4-Lite slave front end: one write and one read under way at a time
`timescale 1ns/1ps
`include "rca_defs.svh"
module rca_axil_slave import rca_pkg::*; (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // Write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // Read address and data
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Register side
  output rca_wr_t o_wr,
  input wire logic i_wr_err,
  output logic o_rd_req,
  output logic [7:0] o_rd_addr,
  input wire logic [31:0] i_rd_data,
  input wire logic i_rd_err
);

  // ==========================================================
  // Handshakes
  rca_axil_state_t s_reg, s_next;

  // Channels stall while a response waits, so only one write is open
  assign o_awready = !s_reg.aw_have && !s_reg.bvalid;
  assign o_wready = !s_reg.w_have && !s_reg.bvalid;
  assign o_arready = !s_reg.rvalid;
  assign o_rd_req = i_arvalid && o_arready;
  assign o_rd_addr = i_araddr;
  assign o_wr = '{req: s_reg.aw_have && s_reg.w_have, addr: s_reg.aw_addr,
                  data: s_reg.w_data, strb: s_reg.w_strb};
  assign o_bvalid = s_reg.bvalid;
  assign o_bresp = s_reg.bresp;
  assign o_rvalid = s_reg.rvalid;
  assign o_rdata = s_reg.rdata;
  assign o_rresp = s_reg.rresp;

  // Next state
  always_comb begin
    s_next = s_reg;
    if (i_awvalid && o_awready) begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      s_next.w_have = 1'b1;
      s_next.w_data = i_wdata;
      s_next.w_strb = i_wstrb;
    end
    if (o_wr.req) begin
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = i_wr_err ? `RCA_RESP_SLVERR : `RCA_RESP_OKAY;
    end else if (s_reg.bvalid && i_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (o_rd_req) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = i_rd_data;
      s_next.rresp = i_rd_err ? `RCA_RESP_SLVERR : `RCA_RESP_OKAY;
    end else if (s_reg.rvalid && i_rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

// ===== verilog/rca_value_window.sv
// Value window: picks the time fields that the pointer exposes
`timescale 1ns/1ps
module rca_value_window import rca_pkg::*; (
  // Pointer and fields
  input wire rca_ptr_t i_ptr,
  input wire rca_fields_t i_fields,
  // Window bytes
  output logic [7:0] o_high_byte,
  output logic o_high_valid,
  output logic [7:0] o_low_byte,
  output logic o_low_valid
);

  // ==========================================================
  // Upper byte table; reserved code shows zero
  always_comb begin
    o_high_valid = 1'b1;
    case (i_ptr)
      RCA_PTR_MINUTES: o_high_byte = i_fields.minutes;
      RCA_PTR_WEEKDAY: o_high_byte = i_fields.weekday;
      RCA_PTR_MONTH: o_high_byte = i_fields.month;
      default: begin
        o_high_byte = 8'h00;
        o_high_valid = 1'b0;
      end
    endcase
  end

  // Lower byte only maps seconds
  assign o_low_valid = (i_ptr == RCA_PTR_MINUTES);
  assign o_low_byte = o_low_valid ? i_fields.seconds : 8'h00;

endmodule

// ===== verilog/rca_rtc_config.sv
// Real-time clock configuration and access control with AXI4-Lite registers
//
// Contract
// - Clock runs only while run enable set
// - Run enable writable only while unlocked
// - Value writes take effect only when unlocked
// - Read-only flag marks possible rollover ripple
// - Half-second bit read-only, cleared by seconds write
// - Configuration reset by power-on reset only
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "rca_defs.svh"
module rca_rtc_config import rca_pkg::*; (
  // Clock and resets
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_sys_rst_n,
  // AXI4-Lite write channels
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [7:0] i_axi_awaddr,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  // AXI4-Lite read channels
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [7:0] i_axi_araddr,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  // Time-keeping counters
  input wire rca_fields_t i_fields,
  input wire logic i_half_sec_tick,
  input wire logic i_rollover_near,
  // Control toward the counters
  output logic o_clock_run,
  output logic o_pulse_out_en,
  output logic [7:0] o_calibration,
  output logic o_field_wr,
  output logic o_field_wr_seconds,
  output rca_ptr_t o_field_wr_ptr,
  output logic [7:0] o_field_wr_data
);

  // ==========================================================
  // Address decode, shared by reads and writes
  function automatic rca_sel_t rca_decode(input logic [7:0] addr);
    case (addr)
      `RCA_OFS_CFG: rca_decode = RCA_SEL_CFG;
      `RCA_OFS_VAL_HIGH: rca_decode = RCA_SEL_HIGH;
      `RCA_OFS_VAL_LOW: rca_decode = RCA_SEL_LOW;
      default: rca_decode = RCA_SEL_NONE;
    endcase
  endfunction

  rca_core_t s_reg, s_next;
  rca_wr_t wr;
  rca_sel_t wr_sel;
  rca_sel_t rd_sel;
  logic rd_req;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic [7:0] win_high;
  logic win_high_ok;
  logic [7:0] win_low;
  logic win_low_ok;
  logic cfg_hi_wr;
  logic high_eff;
  logic low_eff;
  logic [15:0] cfg_word;

  // ==========================================================
  // Bus front end
  rca_axil_slave u_slave (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_awvalid(i_axi_awvalid),
    .o_awready(o_axi_awready),
    .i_awaddr(i_axi_awaddr),
    .i_wvalid(i_axi_wvalid),
    .o_wready(o_axi_wready),
    .i_wdata(i_axi_wdata),
    .i_wstrb(i_axi_wstrb),
    .o_bvalid(o_axi_bvalid),
    .i_bready(i_axi_bready),
    .o_bresp(o_axi_bresp),
    .i_arvalid(i_axi_arvalid),
    .o_arready(o_axi_arready),
    .i_araddr(i_axi_araddr),
    .o_rvalid(o_axi_rvalid),
    .i_rready(i_axi_rready),
    .o_rdata(o_axi_rdata),
    .o_rresp(o_axi_rresp),
    .o_wr(wr),
    .i_wr_err(wr_sel == RCA_SEL_NONE),
    .o_rd_req(rd_req),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data),
    .i_rd_err(rd_sel == RCA_SEL_NONE)
  );

  // Field window for reads and for routing writes
  rca_value_window u_window (
    .i_ptr(s_reg.cfg.ptr),
    .i_fields(i_fields),
    .o_high_byte(win_high),
    .o_high_valid(win_high_ok),
    .o_low_byte(win_low),
    .o_low_valid(win_low_ok)
  );

  // ==========================================================
  // Write qualification
  assign wr_sel = rca_decode(wr.addr);
  assign rd_sel = rca_decode(rd_addr);
  assign cfg_hi_wr = wr.req && (wr_sel == RCA_SEL_CFG) && wr.strb[1];
  // Locked values ignore the write; reserved pointer has no field
  assign high_eff = wr.req && (wr_sel == RCA_SEL_HIGH) && wr.strb[0]
                    && s_reg.cfg.unlock && win_high_ok;
  assign low_eff = wr.req && (wr_sel == RCA_SEL_LOW) && wr.strb[0]
                   && s_reg.cfg.unlock && win_low_ok;

  // Configuration word as software sees it
  always_comb begin
    cfg_word = `RCA_CFG_RESET;
    cfg_word[`RCA_BIT_RUN] = s_reg.cfg.run;
    cfg_word[`RCA_BIT_UNLOCK] = s_reg.cfg.unlock;
    cfg_word[`RCA_BIT_SYNC] = s_reg.sync;
    cfg_word[`RCA_BIT_HALF] = s_reg.half;
    cfg_word[`RCA_BIT_OUTEN] = s_reg.cfg.out_en;
    cfg_word[`RCA_PTR_MSB:`RCA_PTR_LSB] = s_reg.cfg.ptr;
    cfg_word[`RCA_CAL_MSB:`RCA_CAL_LSB] = s_reg.cfg.cal;
  end

  // Read mux; reads have no side effects
  always_comb begin
    case (rd_sel)
      RCA_SEL_CFG: rd_data = {16'h0000, cfg_word};
      RCA_SEL_HIGH: rd_data = {24'h000000, win_high};
      RCA_SEL_LOW: rd_data = {24'h000000, win_low};
      default: rd_data = 32'h00000000;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.fwr = 1'b0;
    // Unlock is judged on the value held before this write
    if (cfg_hi_wr) begin
      if (s_reg.cfg.unlock) begin
        s_next.cfg.run = wr.data[`RCA_BIT_RUN];
      end
      s_next.cfg.unlock = wr.data[`RCA_BIT_UNLOCK];
      s_next.cfg.out_en = wr.data[`RCA_BIT_OUTEN];
      s_next.cfg.ptr = rca_ptr_t'(wr.data[`RCA_PTR_MSB:`RCA_PTR_LSB]);
    end
    if (wr.req && (wr_sel == RCA_SEL_CFG) && wr.strb[0]) begin
      s_next.cfg.cal = wr.data[`RCA_CAL_MSB:`RCA_CAL_LSB];
    end
    // Forward accepted value writes to the counters
    if (high_eff || low_eff) begin
      s_next.fwr = 1'b1;
      s_next.fwr_seconds = low_eff;
      s_next.fwr_ptr = s_reg.cfg.ptr;
      s_next.fwr_data = wr.data[7:0];
    end
    // Flag tracks the counters' ripple window while running
    s_next.sync = s_reg.cfg.run && i_rollover_near;
    // Seconds write restarts the second, so the clear wins over a tick
    if (low_eff) begin
      s_next.half = 1'b0;
    end else if (s_reg.cfg.run && i_half_sec_tick) begin
      s_next.half = !s_reg.half;
    end
    // Other resets spare the software-held configuration; of the configuration word they clear only sync and half
    if (!i_sys_rst_n) begin
      s_next.sync = 1'b0;
      s_next.half = 1'b0;
      s_next.fwr = 1'b0;
    end
  end

  // State register; only power-on reset clears it
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign o_clock_run = s_reg.cfg.run;
  assign o_pulse_out_en = s_reg.cfg.out_en;
  assign o_calibration = s_reg.cfg.cal;
  assign o_field_wr = s_reg.fwr;
  assign o_field_wr_seconds = s_reg.fwr_seconds;
  assign o_field_wr_ptr = s_reg.fwr_ptr;
  assign o_field_wr_data = s_reg.fwr_data;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  property p_run_takes_write;
    cfg_hi_wr && s_reg.cfg.unlock |=> o_clock_run == $past(wr.data[15]);
  endproperty
  a_run_takes_write: assert property (p_run_takes_write)
    else $error("run enable did not follow unlocked write");

  property p_run_locked;
    cfg_hi_wr && !s_reg.cfg.unlock |=> $stable(o_clock_run);
  endproperty
  a_run_locked: assert property (p_run_locked)
    else $error("run enable changed while locked");

  property p_value_locked;
    wr.req && (wr_sel != RCA_SEL_CFG) && !s_reg.cfg.unlock |=> !o_field_wr;
  endproperty
  a_value_locked: assert property (p_value_locked)
    else $error("value write passed while locked");

  property p_sync_flag;
    o_clock_run && i_rollover_near && i_sys_rst_n |=> s_reg.sync ##1 1'b1;
  endproperty
  a_sync_flag: assert property (p_sync_flag)
    else $error("sync flag missing during ripple window");

  property p_half_cleared;
    low_eff && i_sys_rst_n |=> !s_reg.half && o_field_wr && o_field_wr_seconds;
  endproperty
  a_half_cleared: assert property (p_half_cleared)
    else $error("half-second not cleared by seconds write");

  property p_half_toggles;
    o_clock_run && i_half_sec_tick && !low_eff && i_sys_rst_n
      |=> s_reg.half != $past(s_reg.half);
  endproperty
  a_half_toggles: assert property (p_half_toggles)
    else $error("half-second did not toggle on tick");

  property p_cfg_kept;
    !i_sys_rst_n && !wr.req |=> $stable(s_reg.cfg);
  endproperty
  a_cfg_kept: assert property (p_cfg_kept)
    else $error("configuration lost on non power-on reset");

  property p_rsvd_window;
    rd_req && (rd_sel == RCA_SEL_HIGH) && (s_reg.cfg.ptr == RCA_PTR_RSVD)
      |=> o_axi_rvalid && (o_axi_rdata == 32'h00000000);
  endproperty
  a_rsvd_window: assert property (p_rsvd_window)
    else $error("reserved window code returned data");

  // Low byte has no field behind a nonzero pointer
  property p_low_window;
    rd_req && (rd_sel == RCA_SEL_LOW) && (s_reg.cfg.ptr != RCA_PTR_MINUTES)
      |=> o_axi_rvalid && (o_axi_rdata == 32'h00000000);
  endproperty
  a_low_window: assert property (p_low_window)
    else $error("low window returned data for nonzero pointer");

  // Low write under a nonzero pointer must not reach the counters
  property p_seconds_ptr;
    wr.req && (wr_sel == RCA_SEL_LOW) && (s_reg.cfg.ptr != RCA_PTR_MINUTES) |=> !o_field_wr;
  endproperty
  a_seconds_ptr: assert property (p_seconds_ptr)
    else $error("low write passed under nonzero pointer");

  // Stopped clock freezes the half-second state
  property p_half_held;
    !o_clock_run && !low_eff && i_sys_rst_n |=> s_reg.half == $past(s_reg.half);
  endproperty
  a_half_held: assert property (p_half_held)
    else $error("half-second moved while clock stopped");

  // No ripple can happen while the clock is stopped
  property p_sync_stopped;
    !o_clock_run |=> !s_reg.sync;
  endproperty
  a_sync_stopped: assert property (p_sync_stopped)
    else $error("sync flag set while clock stopped");

  // Flag is read-only: only the ripple window raises it
  property p_sync_quiet;
    !i_rollover_near |=> !s_reg.sync;
  endproperty
  a_sync_quiet: assert property (p_sync_quiet)
    else $error("sync flag set outside ripple window");

  // Other reset clears the status bits and the strobe
  property p_sys_reset_clears;
    !i_sys_rst_n |=> !s_reg.sync && !s_reg.half && !o_field_wr;
  endproperty
  a_sys_reset_clears: assert property (p_sys_reset_clears)
    else $error("status kept through other reset");

  // Field strobe lasts a single cycle per accepted write
  property p_field_pulse;
    o_field_wr |=> !o_field_wr;
  endproperty
  a_field_pulse: assert property (p_field_pulse)
    else $error("field strobe longer than one cycle");

endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the clock configuration block
`timescale 1ns/1ps
`include "rca_defs.svh"
module tb_top import rca_pkg::*;;
  // ==========================================================
  // Signals
  logic clk, rst_n, srst_n, awv, wv, bre, arv, rre, tick, near;
  logic awr, wr, bv, arr, rv, run, oen, fw, fws;
  logic [7:0] awa, ara, cal, fwd;
  logic [31:0] wd, rdt, rdat;
  logic [3:0] ws;
  logic [1:0] br, rr, rrsp, brsp;
  rca_ptr_t fwp;
  rca_fields_t fld;
  int err_count, n_checks, fw_n;
  logic fw_sec;
  logic [1:0] fw_ptr;
  logic [7:0] fw_dat;

  rca_rtc_config i_rca_rtc_config (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_sys_rst_n(srst_n),
    .i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_awaddr(awa),
    .i_axi_wvalid(wv), .o_axi_wready(wr), .i_axi_wdata(wd), .i_axi_wstrb(ws),
    .o_axi_bvalid(bv), .i_axi_bready(bre), .o_axi_bresp(br),
    .i_axi_arvalid(arv), .o_axi_arready(arr), .i_axi_araddr(ara),
    .o_axi_rvalid(rv), .i_axi_rready(rre), .o_axi_rdata(rdt), .o_axi_rresp(rr),
    .i_fields(fld), .i_half_sec_tick(tick), .i_rollover_near(near),
    .o_clock_run(run), .o_pulse_out_en(oen), .o_calibration(cal),
    .o_field_wr(fw), .o_field_wr_seconds(fws), .o_field_wr_ptr(fwp),
    .o_field_wr_data(fwd)
  );

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Catch field strobes mid-cycle, away from the launching edge
  always @(negedge clk) begin
    if (fw === 1'b1) begin
      fw_n++;
      fw_sec = fws;
      fw_ptr = fwp;
      fw_dat = fwd;
    end
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Handshakes sampled at negedge; inputs stable until the next rising edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    do begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wr;
      tb = bv;
      brsp = br;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (tb !== 1'b1);
  endtask

  task automatic axr(input logic [7:0] a);
    logic ta, tr;
    arv <= 1'b1;
    ara <= a;
    do begin
      @(negedge clk);
      ta = arv & arr;
      tr = rv;
      rdat = rdt;
      rrsp = rr;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end while (tr !== 1'b1);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    chk(rdat, e);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // Run bit must refuse a write until unlock is already held
  task automatic t_run_lock;
    rchk(`RCA_OFS_CFG, 32'h0);
    axw(`RCA_OFS_CFG, 32'h8000);
    rchk(`RCA_OFS_CFG, 32'h0);
    axw(`RCA_OFS_CFG, 32'h2000);
    axw(`RCA_OFS_CFG, 32'hA000);
    rchk(`RCA_OFS_CFG, 32'hA000);
    chk(run, 1'b1);
    axw(`RCA_OFS_CFG, 32'h2000);
    chk(run, 1'b0);
  endtask

  // Every pointer code, reserved one included
  task automatic t_ptr;
    logic [31:0] hx [4];
    hx = '{32'h11, 32'h22, 32'h33, 32'h0};
    for (int p = 0; p < 4; p++) begin
      axw(`RCA_OFS_CFG, 32'h2000 | (p << 8));
      rchk(`RCA_OFS_VAL_HIGH, hx[p]);
      rchk(`RCA_OFS_VAL_LOW, (p == 0) ? 32'h44 : 32'h0);
    end
  endtask

  // Locked value write must not reach the counters
  task automatic t_value;
    int n0;
    axw(`RCA_OFS_CFG, 32'h0100);
    n0 = fw_n;
    axw(`RCA_OFS_VAL_HIGH, 32'h5A);
    repeat (2) @(posedge clk);
    chk(fw_n, n0);
    axw(`RCA_OFS_CFG, 32'h2100);
    axw(`RCA_OFS_VAL_HIGH, 32'h5A);
    repeat (2) @(posedge clk);
    chk(fw_n, n0 + 1);
    chk({fw_sec, fw_ptr, fw_dat}, {1'b0, 2'h1, 8'h5A});
    axw(`RCA_OFS_VAL_LOW, 32'h33);
    repeat (2) @(posedge clk);
    chk(fw_n, n0 + 1);
  endtask

  // Half bit set by a tick, immune to config writes, cleared by seconds write
  task automatic t_half;
    axw(`RCA_OFS_CFG, 32'hA000);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(`RCA_OFS_CFG, 32'hA800);
    axw(`RCA_OFS_CFG, 32'hA000);
    rchk(`RCA_OFS_CFG, 32'hA800);
    axw(`RCA_OFS_VAL_LOW, 32'h07);
    rchk(`RCA_OFS_CFG, 32'hA000);
    chk({fw_sec, fw_dat}, {1'b1, 8'h07});
  endtask

  // Sync flag follows the ripple window and ignores writes
  task automatic t_sync;
    logic [31:0] v_first;
    axw(`RCA_OFS_CFG, 32'hB000);
    rchk(`RCA_OFS_CFG, 32'hA000);
    near <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(`RCA_OFS_CFG, 32'hB000);
    // Flag set: software reads twice and keeps the value only if both agree
    axr(`RCA_OFS_VAL_HIGH);
    v_first = rdat;
    rchk(`RCA_OFS_VAL_HIGH, v_first);
    chk(v_first, 32'h11);
    near <= 1'b0;
    repeat (3) @(posedge clk);
    rchk(`RCA_OFS_CFG, 32'hA000);
  endtask

  // Other reset keeps the word; power-on reset clears it
  task automatic t_resets;
    axw(`RCA_OFS_CFG, 32'hA7C5);
    srst_n <= 1'b0;
    repeat (3) @(posedge clk);
    srst_n <= 1'b1;
    @(posedge clk);
    rchk(`RCA_OFS_CFG, 32'hA7C5);
    chk({oen, cal}, {1'b1, 8'hC5});
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(`RCA_OFS_CFG, 32'h0);
  endtask

  // Unmapped address answers with an error and no data
  task automatic t_map;
    axr(8'h0C);
    chk({rrsp, rdat}, {2'h2, 32'h0});
    axw(8'h0C, 32'hFFFF);
    chk(brsp, 2'h2);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, srst_n, awv, wv, arv, tick, near} = 7'h20;
    {bre, rre} = 2'h3;
    {awa, ara, wd} = 48'h0;
    ws = 4'hF;
    fld = 32'h11223344;
    err_count = 0;
    n_checks = 0;
    fw_n = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_run_lock();
    t_ptr();
    t_value();
    t_half();
    t_sync();
    t_resets();
    t_map();
    test_done();
  end

  // Watchdog: whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule
